//--- tb/wpf_checker.sv
// Checker: port-level assertions of the protection and receive filter block
`timescale 1ns/1ns
module wpf_checker (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rstn,
    // Transmit side
    input wire logic                  tx_req_valid,
    input wire wpf_pkg::wpf_tx_req_s  tx_req,
    input wire logic                  tx_dec_valid,
    input wire wpf_pkg::wpf_tx_dec_s  tx_dec,
    // Receive side
    input wire logic                  rx_valid,
    input wire logic                  rx_done,
    input wire logic                  rx_discard,
    // Auto response side
    input wire logic                  rsp_valid,
    input wire logic                  rsp_is_cck,
    input wire logic                  rsp_is_cts,
    input wire logic                  rsp_bar_noack,
    input wire logic                  rsp_done,
    input wire wpf_pkg::wpf_rsp_s     rsp_ctl
);
    import wpf_pkg::*;

    // One clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    a_dec_one_cycle: assert property (tx_dec_valid == $past(tx_req_valid))
        else $error("late decision strobe");
    a_dec_holds: assert property (!tx_req_valid |=> $stable(tx_dec))
        else $error("decision moved unasked");
    a_nav_reserved: assert property (tx_dec_valid |-> tx_dec.nav_type != 2'h3)
        else $error("reserved NAV type out");
    a_frame_reserved: assert property (tx_dec_valid |-> tx_dec.frame_type != 2'h3)
        else $error("reserved frame type out");
    a_length_forces_rts: assert property (tx_dec_valid && tx_dec.rts_by_length |->
        tx_dec.frame_type == WPF_PF_RTS_CTS)
        else $error("length rule without RTS");
    a_zero_length: assert property (tx_req_valid && tx_req.length == 20'h0 |=> !tx_dec.rts_by_length)
        else $error("empty frame protected by length");
    a_rx_one_cycle: assert property (rx_done == $past(rx_valid) && (rx_discard -> rx_done))
        else $error("bad verdict timing");
    a_rsp_one_cycle: assert property (rsp_done == $past(rsp_valid))
        else $error("late response strobe");
    a_short_needs_cck: assert property (rsp_valid && !rsp_is_cck |=> !rsp_ctl.cck_short_preamble)
        else $error("short preamble not CCK");
    a_dup_needs_cts: assert property (rsp_valid && !rsp_is_cts |=> !rsp_ctl.duplicate_cts)
        else $error("duplicate on non CTS");
    a_ba_kept: assert property (rsp_valid && !rsp_bar_noack |=> rsp_ctl.send_ba)
        else $error("BA withheld wrongly");

    // Main scenarios
    c_rts_forced: cover property (tx_dec_valid && tx_dec.rts_by_length);
    c_rx_dropped: cover property (rx_discard);
    c_dup_cts: cover property (rsp_done && rsp_ctl.duplicate_cts);
endmodule : wpf_checker

bind wpf_protect_rx_filter wpf_checker wpf_checker_inst (.clk, .rstn, .tx_req_valid, .tx_req, .tx_dec_valid,
    .tx_dec, .rx_valid, .rx_done, .rx_discard, .rsp_valid, .rsp_is_cck, .rsp_is_cts, .rsp_bar_noack, .rsp_done,
    .rsp_ctl);

//--- tb/wpf_protect_rx_filter_bench.sv
// Testbench: register map, protection decisions, receive filter and auto responses
`timescale 1ns/1ns
module wpf_protect_rx_filter_bench;
    import wpf_pkg::*;

    logic         clk, rstn, reg_wr, reg_rd, tx_req_valid, tx_dec_valid, rx_valid, rx_done, rx_discard;
    logic         rsp_valid, rsp_is_cck, rsp_is_cts, rsp_bar_noack, ext_cca_busy, rsp_done;
    logic [15:0]  reg_addr;
    logic [31:0]  reg_wdata, reg_rdata;
    wpf_tx_req_s  tx_req;
    wpf_tx_dec_s  tx_dec;
    wpf_rx_info_s rx_info;
    wpf_rsp_s     rsp_ctl;
    int           n_mismatch = 0;
    int           num_checks = 0;

    // Map order: six class sets, CTS, ACK, filter, auto, threshold
    localparam logic [15:0] ADDR [11] = '{16'h1364, 16'h1368, 16'h136C, 16'h1370, 16'h1374, 16'h1378,
                                          16'h137C, 16'h1380, 16'h1400, 16'h1404, 16'h1344};
    localparam logic [31:0] RST [11] = '{32'h0010_0003, 32'h0020_0003, 32'h0040_4004, 32'h0080_4084,
        32'h0100_4004, 32'h0100_4084, 32'h0038_013A, 32'h0024_00CA, 32'h0001_5F9F, 32'h0000_0002, 32'h00FF_FF00};
    localparam logic [31:0] MSK [11] = '{32'h07FF_FFFF, 32'h07FF_FFFF, 32'h07FF_FFFF, 32'h07FF_FFFF,
        32'h07FF_FFFF, 32'h07FF_FFFF, 32'h7FFF_7FFF, 32'h7FFF_7FFF, 32'h0001_FFFF, 32'h0000_00DE, 32'h00FF_FF00};

    wpf_protect_rx_filter wpf_protect_rx_filter_inst (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .tx_req_valid, .tx_req, .tx_dec_valid, .tx_dec, .rx_valid, .rx_info, .rx_done, .rx_discard,
        .rsp_valid, .rsp_is_cck, .rsp_is_cts, .rsp_bar_noack, .ext_cca_busy, .rsp_done, .rsp_ctl);
    wpf_station_model wpf_station_model_inst (.clk, .rx_valid, .rx_info, .rsp_valid, .rsp_is_cck, .rsp_is_cts,
        .rsp_bar_noack, .ext_cca_busy);

    ////////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_out(what, 64'(exp), 64'(got));
    endtask : cmp_reg

    task automatic cmp_out(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_out

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
    endtask : do_reset

    task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data taken in the one cycle they stand
    task automatic rd_cmp(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 cmp_reg($sformatf("reg %h", a), exp, reg_rdata);
    endtask : rd_cmp

    task automatic tx_case(input wpf_class_e c, input logic [19:0] len, input logic [57:0] exp);
        @(posedge clk);
        tx_req_valid <= 1'b1;
        tx_req <= '{phy_class: c, length: len};
        @(posedge clk);
        tx_req_valid <= 1'b0;
        #1 cmp_out("tx_dec", 64'(exp), 64'({tx_dec_valid, tx_dec}));
    endtask : tx_case

    task automatic rx_case(input logic [12:0] info, input logic exp);
        wpf_station_model_inst.send_frame(info);
        #1 cmp_out("rx_discard", 64'({1'b1, exp}), 64'({rx_done, rx_discard}));
    endtask : rx_case

    // Expected decision from the rules; code 3 is none, length wins
    function automatic logic [57:0] dec_exp(input logic [31:0] cfg, input logic cck, input logic [19:0] len,
                                            input logic [15:0] thr, input logic [31:0] cts, input logic [31:0] ack);
        logic [1:0] fr;
        logic [1:0] nv;
        logic       rl;
        rl = cfg[26] && (len > {4'h0, thr});
        fr = rl ? 2'h1 : ((cfg[17:16] == 2'h3) ? 2'h0 : cfg[17:16]);
        nv = (cfg[19:18] == 2'h3) ? 2'h0 : cfg[19:18];
        return {1'b1, fr, nv, cfg[15:0], cfg[25:20], rl, cck ? cts[14:0] : cts[30:16], cck ? ack[14:0] : ack[30:16]};
    endfunction : dec_exp

    // Hang guard, past the few thousand cycles needed
    initial begin
        #200_000;
        n_mismatch++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin : main
        logic [31:0] d;
        logic [19:0] len [3];
        int i, j, k;
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, tx_req_valid, tx_req} = '0;
        len = '{20'h00100, 20'h00101, 20'hFFFFF};
        do_reset();
        // Reset values, unmapped read
        for (i = 0; i < 11; i++) rd_cmp(ADDR[i], RST[i]);
        rd_cmp(16'h1390, 32'h0);
        // Writable bits of every register, unmapped write ignored
        for (i = 0; i < 11; i++) begin
            reg_write(ADDR[i], 32'hFFFF_FFFF);
            rd_cmp(ADDR[i], MSK[i]);
        end
        reg_write(16'h1390, 32'hFFFF_FFFF);
        rd_cmp(16'h1390, 32'h0);
        // Reset again after reprogramming; each class uses its own set
        do_reset();
        for (i = 0; i < 6; i++) tx_case(wpf_class_e'(i), 20'h0, dec_exp(RST[i], i == 0, 20'h0, 16'hFFFF,
            RST[6], RST[7]));
        // Every NAV and frame code, reserved ones included
        for (i = 0; i < 4; i++) begin
            d = 32'h03F0_1234 | (32'(i) << 18) | (32'(i) << 16);
            reg_write(WPF_OFDM_PROT_OFS, d);
            tx_case(WPF_CLS_OFDM, 20'h0, dec_exp(d, 1'b0, 20'h0, 16'hFFFF, RST[6], RST[7]));
        end
        // Length threshold at its boundary, where the class enables it; then CCK, above it, where its class does not
        reg_write(WPF_RTS_THRESH_OFS, 32'h0001_0000);
        reg_write(WPF_MM20_PROT_OFS, 32'h0442_4004);
        reg_write(WPF_EXP_CTS_OFS, 32'h1234_0567);
        reg_write(WPF_EXP_ACK_OFS, 32'h0765_4321);
        for (i = 0; i < 3; i++) tx_case(WPF_CLS_MM20, len[i], dec_exp(32'h0442_4004, 1'b0, len[i], 16'h0100,
                                        32'h1234_0567, 32'h0765_4321));
        tx_case(WPF_CLS_CCK, 20'h00101, dec_exp(RST[0], 1'b1, 20'h00101, 16'h0100,
                32'h1234_0567, 32'h0765_4321));
        // Filter at reset, then every enable inverted
        for (k = 0; k < 2; k++) begin
            d = (k == 1) ? 32'h0000_A060 : RST[8];
            if (k == 1) reg_write(WPF_RX_FILTER_OFS, d);
            rx_case(13'h0, 1'b0);
            for (i = 0; i < 8; i++) rx_case(13'(1 << i), d[i]);
            for (i = 0; i < 16; i++) rx_case({1'b1, 4'(i), 8'h0}, d[(i < 8) ? 16 : 23 - i]);
        end
        // Every response setting against every request
        for (k = 0; k < 64; k++) begin
            reg_write(WPF_AUTO_RSP_OFS, {24'h0, k[5:4], 1'b0, k[3:0], 1'b0});
            for (j = 0; j < 16; j++) begin
                wpf_station_model_inst.ask_response(j[3], j[2], j[1], j[0]);
                #1 cmp_out("rsp_ctl", 64'({1'b1, k[5], k[4], j[3] & k[3], j[2] & k[1] & !(k[2] & j[0]),
                           !(k[0] & j[1])}), 64'({rsp_done, rsp_ctl}));
            end
        end
        end_of_test();
    end
endmodule : wpf_protect_rx_filter_bench

//--- tb/wpf_station_model.sv
// Partner: the medium side, presents received frames and response requests
`timescale 1ns/1ns
module wpf_station_model (
    // Clock
    input  wire logic             clk,
    // Received frame
    output logic                  rx_valid,
    output wpf_pkg::wpf_rx_info_s rx_info,
    // Response request
    output logic                  rsp_valid,
    output logic                  rsp_is_cck,
    output logic                  rsp_is_cts,
    output logic                  rsp_bar_noack,
    output logic                  ext_cca_busy
);
    import wpf_pkg::*;

    // Idle at time zero
    initial begin
        rx_valid = 1'b0;
        rx_info = '0;
        {rsp_valid, rsp_is_cck, rsp_is_cts, rsp_bar_noack, ext_cca_busy} = 5'h0;
    end

    // One frame; attributes invert once released
    task automatic send_frame(input logic [12:0] info);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_info <= info;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_info <= ~info;
    endtask : send_frame

    // One response request with its qualifiers
    task automatic ask_response(input logic cck, input logic cts, input logic noack, input logic busy);
        @(posedge clk);
        rsp_valid <= 1'b1;
        {rsp_is_cck, rsp_is_cts, rsp_bar_noack, ext_cca_busy} <= {cck, cts, noack, busy};
        @(posedge clk);
        rsp_valid <= 1'b0;
        {rsp_is_cck, rsp_is_cts, rsp_bar_noack, ext_cca_busy} <= ~{cck, cts, noack, busy};
    endtask : ask_response
endmodule : wpf_station_model

//--- verilog/wpf_pkg.sv
// Package: register map, fields, reset values and carriers of the protection and receive filter block
package wpf_pkg;

    // Register byte offsets
    localparam logic [15:0] WPF_CCK_PROT_OFS   = 16'h1364;
    localparam logic [15:0] WPF_OFDM_PROT_OFS  = 16'h1368;
    localparam logic [15:0] WPF_MM20_PROT_OFS  = 16'h136C;
    localparam logic [15:0] WPF_MM40_PROT_OFS  = 16'h1370;
    localparam logic [15:0] WPF_GF20_PROT_OFS  = 16'h1374;
    localparam logic [15:0] WPF_GF40_PROT_OFS  = 16'h1378;
    localparam logic [15:0] WPF_EXP_CTS_OFS    = 16'h137C;
    localparam logic [15:0] WPF_EXP_ACK_OFS    = 16'h1380;
    localparam logic [15:0] WPF_RX_FILTER_OFS  = 16'h1400;
    localparam logic [15:0] WPF_AUTO_RSP_OFS   = 16'h1404;
    localparam logic [15:0] WPF_RTS_THRESH_OFS = 16'h1344;

    // Protection config field positions
    localparam int WPF_RTSTH_BIT   = 26;
    localparam int WPF_TXOP_LSB    = 20;
    localparam int WPF_NAV_LSB     = 18;
    localparam int WPF_FRAME_LSB   = 16;
    localparam int WPF_RATE_LSB    = 0;
    localparam int WPF_UPPER_LSB   = 16;
    localparam int WPF_RTS_THR_LSB = 8;

    // Writable bit masks
    localparam logic [31:0] WPF_PROT_MASK    = 32'h07FF_FFFF;
    localparam logic [31:0] WPF_TIME_MASK    = 32'h7FFF_7FFF;
    localparam logic [31:0] WPF_FILTER_MASK  = 32'h0001_FFFF;
    localparam logic [31:0] WPF_AUTO_MASK    = 32'h0000_00DE;
    localparam logic [31:0] WPF_RTS_THR_MASK = 32'h00FF_FF00;

    // Reset values
    localparam logic [31:0] WPF_CCK_PROT_RST  = 32'h0010_0003;
    localparam logic [31:0] WPF_OFDM_PROT_RST = 32'h0020_0003;
    localparam logic [31:0] WPF_MM20_PROT_RST = 32'h0040_4004;
    localparam logic [31:0] WPF_MM40_PROT_RST = 32'h0080_4084;
    localparam logic [31:0] WPF_GF20_PROT_RST = 32'h0100_4004;
    localparam logic [31:0] WPF_GF40_PROT_RST = 32'h0100_4084;
    localparam logic [31:0] WPF_EXP_CTS_RST   = 32'h0038_013A;
    localparam logic [31:0] WPF_EXP_ACK_RST   = 32'h0024_00CA;
    localparam logic [31:0] WPF_RX_FILTER_RST = 32'h0001_5F9F;
    localparam logic [31:0] WPF_AUTO_RSP_RST  = 32'h0000_0002;
    localparam logic [31:0] WPF_RTS_THR_RST   = 32'h00FF_FF00;

    // Receive filter bit positions
    localparam int WPF_RX_CTRL_LSB = 8;
    localparam int WPF_RX_DUPL     = 7;
    localparam int WPF_RX_BCAST    = 6;
    localparam int WPF_RX_MCAST    = 5;
    localparam int WPF_RX_VER      = 4;
    localparam int WPF_RX_FOREIGN  = 3;
    localparam int WPF_RX_NOT_OURS = 2;
    localparam int WPF_RX_PHY      = 1;
    localparam int WPF_RX_CRC      = 0;

    // Auto response bit positions
    localparam int WPF_AR_PWR     = 7;
    localparam int WPF_AR_BAACK   = 6;
    localparam int WPF_AR_SHORT   = 4;
    localparam int WPF_AR_EXTCCA  = 3;
    localparam int WPF_AR_DUPCTS  = 2;
    localparam int WPF_AR_HONOR   = 1;

    // Transmit PHY classes, index of the config set
    typedef enum logic [2:0] {
        WPF_CLS_CCK, WPF_CLS_OFDM, WPF_CLS_MM20, WPF_CLS_MM40, WPF_CLS_GF20, WPF_CLS_GF40
    } wpf_class_e;

    typedef enum logic [1:0] {WPF_NAV_NONE, WPF_NAV_SHORT, WPF_NAV_LONG} wpf_nav_e;
    typedef enum logic [1:0] {WPF_PF_NONE, WPF_PF_RTS_CTS, WPF_PF_CTS_SELF} wpf_frame_e;

    // Transmit request
    typedef struct packed {
        wpf_class_e  phy_class;
        logic [19:0] length;
    } wpf_tx_req_s;

    // Protection decision
    typedef struct packed {
        wpf_frame_e  frame_type;
        wpf_nav_e    nav_type;
        logic [15:0] rate;
        logic [5:0]  txop_allow;
        logic        rts_by_length;
        logic [14:0] cts_us;
        logic [14:0] ack_us;
    } wpf_tx_dec_s;

    // Received frame attributes
    typedef struct packed {
        logic       is_ctrl;
        logic [3:0] ctrl_subtype;
        logic       duplicate;
        logic       broadcast;
        logic       multicast;
        logic       version_error;
        logic       foreign_bss;
        logic       unicast_not_ours;
        logic       phy_error;
        logic       crc_error;
    } wpf_rx_info_s;

    // Auto response controls
    typedef struct packed {
        logic power_bit;
        logic ba_ack_policy;
        logic cck_short_preamble;
        logic duplicate_cts;
        logic send_ba;
    } wpf_rsp_s;

endpackage : wpf_pkg

//--- verilog/wpf_protect_rx_filter.sv
// Module: transmit protection selection, NAV response times, receive filter and auto response control
`timescale 1ns/1ns

// Summary of operation
// - Two-bit NAV type per class: none, short, long; code 3 treated as none.
// - Two-bit protection frame type per class: none, RTS/CTS, CTS-to-self; 3 is none.
// - Six-bit TXOP allowance per class, bits CCK..GF-40, one allows that class.
// - Bit 26 per class enables the RTS length threshold for that class.
// - Sixteen-bit protection frame rate per class; CCK resets to 0x3.
// - 20 MHz HT classes reset rate to 0x4004, 40 MHz classes to 0x4084.
// - Allowance masks reset to own class, except GF-40; both greenfield classes reset to 0x10.
// - Expected OFDM CTS time, fifteen bits in us, resets to 0x38.
// - Expected CCK CTS time, fifteen bits in us, resets to 0x13A.
// - Expected ACK times: OFDM upper resets 0x24, CCK lower resets 0xCA.
// - Bits 16..8 discard control frames by subtype when set.
// - Discard duplicates, broadcast, multicast, foreign BSS, unicast not ours when enabled.
// - Discard version errors, PHY errors and CRC errors when enabled.
// - Programmed bit 7 goes into power bit of automatic control responses.
// - Programmed bit 6 goes into BA control ACK policy bit.
// - Bit 4 set sends automatic CCK responses with short preamble.
// - Bit 2 duplicates legacy CTS over 40 MHz; bit 3 gates it by extension CCA.
// - Bit 1 set suppresses BA for no-ACK BAR; resets to one.
// - With threshold enabled, frames longer than the byte threshold get RTS/CTS.
module wpf_protect_rx_filter (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // Register port
    input  wire logic [15:0]           reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [31:0]                reg_rdata,
    // Transmit protection request and decision
    input  wire logic                  tx_req_valid,
    input  wire wpf_pkg::wpf_tx_req_s  tx_req,
    output logic                       tx_dec_valid,
    output wpf_pkg::wpf_tx_dec_s       tx_dec,
    // Received frame classification
    input  wire logic                  rx_valid,
    input  wire wpf_pkg::wpf_rx_info_s rx_info,
    output logic                       rx_done,
    output logic                       rx_discard,
    // Auto response request and controls
    input  wire logic                  rsp_valid,
    input  wire logic                  rsp_is_cck,
    input  wire logic                  rsp_is_cts,
    input  wire logic                  rsp_bar_noack,
    input  wire logic                  ext_cca_busy,
    output logic                       rsp_done,
    output wpf_pkg::wpf_rsp_s          rsp_ctl
);
    import wpf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [31:0] prot_reg [6];
    logic [31:0] exp_cts_reg;
    logic [31:0] exp_ack_reg;
    logic [31:0] rx_filter_reg;
    logic [31:0] auto_rsp_reg;
    logic [31:0] rts_thr_reg;

    localparam logic [15:0] PROT_OFS [6] = '{WPF_CCK_PROT_OFS, WPF_OFDM_PROT_OFS, WPF_MM20_PROT_OFS,
                                             WPF_MM40_PROT_OFS, WPF_GF20_PROT_OFS, WPF_GF40_PROT_OFS};
    localparam logic [31:0] PROT_RST [6] = '{WPF_CCK_PROT_RST, WPF_OFDM_PROT_RST, WPF_MM20_PROT_RST,
                                             WPF_MM40_PROT_RST, WPF_GF20_PROT_RST, WPF_GF40_PROT_RST};

    // One config set per PHY class; reserved bits never store
    for (genvar i = 0; i < 6; i++) begin : g_prot
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                prot_reg[i] <= PROT_RST[i];
            end else if (reg_wr && reg_addr == PROT_OFS[i]) begin
                prot_reg[i] <= reg_wdata & WPF_PROT_MASK;
            end
        end
    end

    // Expected response times for outgoing NAV
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            exp_cts_reg <= WPF_EXP_CTS_RST;
            exp_ack_reg <= WPF_EXP_ACK_RST;
        end else if (reg_wr && reg_addr == WPF_EXP_CTS_OFS) begin
            exp_cts_reg <= reg_wdata & WPF_TIME_MASK;
        end else if (reg_wr && reg_addr == WPF_EXP_ACK_OFS) begin
            exp_ack_reg <= reg_wdata & WPF_TIME_MASK;
        end
    end

    // Receive filter, auto response and RTS threshold
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_filter_reg <= WPF_RX_FILTER_RST;
            auto_rsp_reg  <= WPF_AUTO_RSP_RST;
            rts_thr_reg   <= WPF_RTS_THR_RST;
        end else if (reg_wr) begin
            if (reg_addr == WPF_RX_FILTER_OFS) begin
                rx_filter_reg <= reg_wdata & WPF_FILTER_MASK;
            end else if (reg_addr == WPF_AUTO_RSP_OFS) begin
                auto_rsp_reg <= reg_wdata & WPF_AUTO_MASK;
            end else if (reg_addr == WPF_RTS_THRESH_OFS) begin
                rts_thr_reg <= reg_wdata & WPF_RTS_THR_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port, data one cycle after the strobe

    logic [31:0] rdata_next;

    // Unmapped addresses read as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_addr == WPF_CCK_PROT_OFS) begin
            rdata_next = prot_reg[WPF_CLS_CCK];
        end else if (reg_addr == WPF_OFDM_PROT_OFS) begin
            rdata_next = prot_reg[WPF_CLS_OFDM];
        end else if (reg_addr == WPF_MM20_PROT_OFS) begin
            rdata_next = prot_reg[WPF_CLS_MM20];
        end else if (reg_addr == WPF_MM40_PROT_OFS) begin
            rdata_next = prot_reg[WPF_CLS_MM40];
        end else if (reg_addr == WPF_GF20_PROT_OFS) begin
            rdata_next = prot_reg[WPF_CLS_GF20];
        end else if (reg_addr == WPF_GF40_PROT_OFS) begin
            rdata_next = prot_reg[WPF_CLS_GF40];
        end else if (reg_addr == WPF_EXP_CTS_OFS) begin
            rdata_next = exp_cts_reg;
        end else if (reg_addr == WPF_EXP_ACK_OFS) begin
            rdata_next = exp_ack_reg;
        end else if (reg_addr == WPF_RX_FILTER_OFS) begin
            rdata_next = rx_filter_reg;
        end else if (reg_addr == WPF_AUTO_RSP_OFS) begin
            rdata_next = auto_rsp_reg;
        end else if (reg_addr == WPF_RTS_THRESH_OFS) begin
            rdata_next = rts_thr_reg;
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit protection decision

    logic [31:0] sel_cfg;
    logic [1:0]  sel_nav;
    logic [1:0]  sel_frame;
    logic        is_cck;
    logic        over_thr;
    wpf_tx_dec_s dec_next;

    assign sel_cfg   = prot_reg[tx_req.phy_class];
    assign sel_nav   = sel_cfg[WPF_NAV_LSB +: 2];
    assign sel_frame = sel_cfg[WPF_FRAME_LSB +: 2];
    assign is_cck    = (tx_req.phy_class == WPF_CLS_CCK);
    // Length compares against the 16-bit byte threshold; A-MPDU lengths may exceed 16 bits
    assign over_thr  = sel_cfg[WPF_RTSTH_BIT] &&
                       (tx_req.length > {4'h0, rts_thr_reg[WPF_RTS_THR_LSB +: 16]});

    // Decode fields; reserved codes fall back to none
    always_comb begin
        dec_next = '0;
        case (sel_nav)
            2'h1: dec_next.nav_type = WPF_NAV_SHORT;
            2'h2: dec_next.nav_type = WPF_NAV_LONG;
            default: dec_next.nav_type = WPF_NAV_NONE;
        endcase
        case (sel_frame)
            2'h1: dec_next.frame_type = WPF_PF_RTS_CTS;
            2'h2: dec_next.frame_type = WPF_PF_CTS_SELF;
            default: dec_next.frame_type = WPF_PF_NONE;
        endcase
        // Length threshold forces RTS/CTS even when the class asks for less
        if (over_thr) begin
            dec_next.frame_type = WPF_PF_RTS_CTS;
        end
        dec_next.rts_by_length = over_thr;
        dec_next.rate          = sel_cfg[WPF_RATE_LSB +: 16];
        dec_next.txop_allow    = sel_cfg[WPF_TXOP_LSB +: 6];
        dec_next.cts_us        = is_cck ? exp_cts_reg[14:0] : exp_cts_reg[WPF_UPPER_LSB +: 15];
        dec_next.ack_us        = is_cck ? exp_ack_reg[14:0] : exp_ack_reg[WPF_UPPER_LSB +: 15];
    end

    // Decision registered one cycle after the request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_dec_valid <= 1'b0;
            tx_dec       <= '0;
        end else begin
            tx_dec_valid <= tx_req_valid;
            if (tx_req_valid) begin
                tx_dec <= dec_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive filter

    logic       ctrl_drop;
    logic       rx_drop_next;
    logic [8:0] ctrl_en;

    assign ctrl_en = rx_filter_reg[WPF_RX_CTRL_LSB +: 9];

    // Control subtype to enable bit: 8 BAR .. 15 CF-END+CF-ACK, others reserved
    always_comb begin
        case (rx_info.ctrl_subtype)
            4'h8: ctrl_drop = ctrl_en[7];
            4'h9: ctrl_drop = ctrl_en[6];
            4'hA: ctrl_drop = ctrl_en[5];
            4'hB: ctrl_drop = ctrl_en[4];
            4'hC: ctrl_drop = ctrl_en[3];
            4'hD: ctrl_drop = ctrl_en[2];
            4'hE: ctrl_drop = ctrl_en[1];
            4'hF: ctrl_drop = ctrl_en[0];
            default: ctrl_drop = ctrl_en[8];
        endcase
    end

    assign rx_drop_next = (rx_info.is_ctrl && ctrl_drop) ||
                          (rx_info.duplicate && rx_filter_reg[WPF_RX_DUPL]) ||
                          (rx_info.broadcast && rx_filter_reg[WPF_RX_BCAST]) ||
                          (rx_info.multicast && rx_filter_reg[WPF_RX_MCAST]) ||
                          (rx_info.foreign_bss && rx_filter_reg[WPF_RX_FOREIGN]) ||
                          (rx_info.unicast_not_ours && rx_filter_reg[WPF_RX_NOT_OURS]) ||
                          (rx_info.version_error && rx_filter_reg[WPF_RX_VER]) ||
                          (rx_info.phy_error && rx_filter_reg[WPF_RX_PHY]) ||
                          (rx_info.crc_error && rx_filter_reg[WPF_RX_CRC]);

    // Verdict registered, one cycle after the frame attributes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_done    <= 1'b0;
            rx_discard <= 1'b0;
        end else begin
            rx_done    <= rx_valid;
            rx_discard <= rx_valid && rx_drop_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auto response controls

    wpf_rsp_s rsp_next;

    always_comb begin
        rsp_next                    = '0;
        rsp_next.power_bit          = auto_rsp_reg[WPF_AR_PWR];
        rsp_next.ba_ack_policy      = auto_rsp_reg[WPF_AR_BAACK];
        rsp_next.cck_short_preamble = rsp_is_cck && auto_rsp_reg[WPF_AR_SHORT];
        // Extension CCA only matters when the check is enabled
        rsp_next.duplicate_cts      = rsp_is_cts && auto_rsp_reg[WPF_AR_DUPCTS] &&
                                      !(auto_rsp_reg[WPF_AR_EXTCCA] && ext_cca_busy);
        rsp_next.send_ba            = !(auto_rsp_reg[WPF_AR_HONOR] && rsp_bar_noack);
    end

    // Controls held until the next response request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsp_done <= 1'b0;
            rsp_ctl  <= '0;
        end else begin
            rsp_done <= rsp_valid;
            if (rsp_valid) begin
                rsp_ctl <= rsp_next;
            end
        end
    end

endmodule : wpf_protect_rx_filter
